// >>> ap_audio_port.sv
`include "ap_defs.svh"
module ap_audio_port #(
  parameter int CNT_W = 16 // Width of the word select period counter.
) (
  input logic clock, // Device clock, 200 MHz.
  input logic rst, // Synchronous reset, active high.
  input logic cfg_done, // Configuration read routine finished.
  input logic transmitter_role, // Role strap pin, high for transmitter.
  input logic [6:0] reg_addr, // Register address.
  input logic reg_wr, // Register write strobe.
  input logic reg_rd, // Register read strobe.
  input logic [7:0] reg_wdata, // Register write data.
  output logic [7:0] reg_rdata, // Register read data.
  input logic mem_cs_src_n, // Memory master chip select.
  input logic mem_sck_src, // Memory master clock.
  input logic mem_out_src, // Memory master data out.
  output logic mem_chip_select_n, // Memory chip select pin.
  output logic mem_serial_clock, // Memory clock pin.
  output logic mem_serial_out, // Memory data out pin.
  input logic req_i, // Request pin input.
  output logic req_o, // Request pin output.
  output logic req_oe, // Request pin enable.
  input logic bclk_i, // Bit clock pin input.
  output logic bclk_o, // Bit clock pin output.
  output logic bclk_oe, // Bit clock pin enable.
  input logic ws_i, // Word select pin input.
  output logic ws_o, // Word select pin output.
  output logic ws_oe, // Word select pin enable.
  input logic data_i, // Audio data pin input.
  output logic data_o, // Audio data pin output.
  output logic data_oe, // Audio data pin enable.
  input logic spdif_pin_i, // S/PDIF pin input.
  output logic spdif_pin_o, // S/PDIF pin output.
  output logic spdif_pin_oe, // S/PDIF pin enable.
  output logic mclk_o, // Master clock pin.
  output logic mclk_oe, // Master clock pin enable.
  input logic [2:0] direct_data_input, // Direct data pins.
  input logic two_wire_sel, // Slave interface select pin.
  input logic req_active, // Buffer wants data.
  input logic arx_data_bit, // Serial data to send.
  input logic arx_spdif_bit, // S/PDIF line code to send.
  input logic spdif_as_reset, // Use S/PDIF pin as reset.
  input logic ext_reset_req, // Assert external reset.
  input logic smp_valid, // Audio sample strobe.
  input logic [23:0] smp_data, // Signed audio sample.
  input logic smp_frame_end, // Last sample of a frame.
  output logic [4:0] cmp_shift, // Low bits to drop.
  output logic cmp_valid, // Shift update pulse.
  input logic sp_valid, // S/PDIF subframe strobe.
  input logic [23:0] sp_payload, // Subframe payload.
  input logic [7:0] sp_idx, // Frame index in block.
  input logic sp_cs, // Channel status bit.
  output logic sp_out_valid, // Payload strobe out.
  output logic [23:0] sp_out_payload, // Payload out.
  output logic [31:0] cs_word, // Channel status word.
  output logic cs_valid, // Status word pulse.
  output logic role_tx, // Latched role.
  output logic [1:0] rate_scale, // Active scale code.
  output logic [1:0] rate_fund, // Active rate code.
  output ap_pkg::ap_fmt_t fmt_mode, // Active format.
  output logic rf_tx_enable, // RF transmitter enable.
  output logic audio_tx_power_down, // Audio power down.
  output logic wake_pulse, // Direct data 1 changed.
  output logic [2:0] dd_out, // Direct data bits.
  output logic ser_bclk, // Synced bit clock.
  output logic ser_ws, // Synced word select.
  output logic ser_data, // Synced data.
  output logic rx_req_seen, // Synced request input.
  output logic spdif_in // Synced S/PDIF input.
);
  import ap_pkg::*;

  localparam logic [31:0] INC48 = 32'((64'(`AP_MCLK_MUL * `AP_FS_48) << 32) / 64'(`AP_CLK_HZ));
  localparam logic [31:0] INC441 = 32'((64'(`AP_MCLK_MUL * `AP_FS_441) << 32) / 64'(`AP_CLK_HZ));
  localparam logic [31:0] INC32 = 32'((64'(`AP_MCLK_MUL * `AP_FS_32) << 32) / 64'(`AP_CLK_HZ));

  // Word select period to rate codes; the 16 kHz slot is left out on purpose.
  function automatic logic [3:0] rate_code(input logic [CNT_W-1:0] per);
    logic [3:0] r;
    int fs;
    int nom;
    r = {AP_SC_ONE, AP_FUND_NONE};
    for (int f = 0; f < 3; f++) begin
      for (int s = 0; s < 3; s++) begin
        fs = (f == 0) ? `AP_FS_48 : (f == 1) ? `AP_FS_441 : `AP_FS_32;
        nom = (`AP_CLK_HZ / fs) << (2 - s);
        if (!(f == 2 && s == 1) && int'(per) > nom - (nom >> `AP_TOL_SHIFT) &&
            int'(per) < nom + (nom >> `AP_TOL_SHIFT)) begin
          r = {2'(s), 2'(f)};
        end
      end
    end
    return r;
  endfunction

  // Magnitude of a signed sample.
  function automatic logic [23:0] mag(input logic [23:0] x);
    return x[23] ? 24'(~x + 24'h000001) : x;
  endfunction

  // Two flip-flops on every pin input; stage one feeds only stage two.
  logic [9:0] s1_q, s2_q;
  always_ff @(posedge clock) begin
    s1_q <= {two_wire_sel, direct_data_input, spdif_pin_i, req_i, data_i, bclk_i, ws_i, transmitter_role};
    s2_q <= s1_q;
  end

  // Software copies, active shadows and boot state.
  ap_state_t st_q, st_d;
  logic [7:0] sw_rate_q, sw_rate_d, sw_fmt_q, sw_fmt_d, sw_mod_q, sw_mod_d;
  logic [7:0] sw_cfg_q, sw_cfg_d, sw_rxm_q, sw_rxm_d, sw_lnk_q, sw_lnk_d;
  logic [7:0] ac_rate_q, ac_rate_d, ac_fmt_q, ac_fmt_d, ac_mod_q, ac_mod_d;
  logic [7:0] ac_cfg_q, ac_cfg_d, ac_rxm_q, ac_rxm_d, rdata_q, rdata_d;
  logic reconf_q, reconf_d, role_q, role_d;
  logic [3:0] det_q, det_d;
  always_comb begin
    st_d = st_q;
    role_d = role_q;
    if (st_q == AP_ST_BOOT && cfg_done) begin
      st_d = AP_ST_RUN;
      role_d = s2_q[0];
    end
    sw_rate_d = sw_rate_q;
    sw_fmt_d = sw_fmt_q;
    sw_mod_d = sw_mod_q;
    sw_cfg_d = sw_cfg_q;
    sw_rxm_d = sw_rxm_q;
    sw_lnk_d = sw_lnk_q;
    reconf_d = 1'b0;
    if (reg_wr) begin
      unique case (reg_addr)
        `AP_ADR_RATE: sw_rate_d = reg_wdata;
        `AP_ADR_FMT: sw_fmt_d = reg_wdata;
        `AP_ADR_TRANSMITTER_OPERATION_MODE: sw_mod_d = reg_wdata;
        `AP_ADR_INCFG: sw_cfg_d = reg_wdata;
        `AP_ADR_RECEIVER_OPERATION_MODE: sw_rxm_d = reg_wdata;
        `AP_ADR_LINK: begin
          sw_lnk_d = reg_wdata & ~(8'h01 << `AP_B_RECONF);
          reconf_d = reg_wdata[`AP_B_RECONF];
        end
        default: ;
      endcase
    end
    // Shadows only move on the reconfigure pulse, so half-written setups never reach the pins.
    ac_rate_d = reconf_q ? sw_rate_q : ac_rate_q;
    ac_fmt_d = reconf_q ? sw_fmt_q : ac_fmt_q;
    ac_mod_d = reconf_q ? sw_mod_q : ac_mod_q;
    ac_cfg_d = reconf_q ? sw_cfg_q : ac_cfg_q;
    ac_rxm_d = reconf_q ? sw_rxm_q : ac_rxm_q;
    rdata_d = rdata_q;
    if (reg_rd) begin
      unique case (reg_addr)
        `AP_ADR_RATE: rdata_d = sw_rate_q[`AP_B_AUTO] ?
          {sw_rate_q[7], det_q, sw_rate_q[2:0]} : sw_rate_q;
        `AP_ADR_FMT: rdata_d = sw_fmt_q;
        `AP_ADR_TRANSMITTER_OPERATION_MODE: rdata_d = sw_mod_q;
        `AP_ADR_INCFG: rdata_d = sw_cfg_q;
        `AP_ADR_RECEIVER_OPERATION_MODE: rdata_d = sw_rxm_q;
        `AP_ADR_LINK: rdata_d = sw_lnk_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      st_q <= AP_ST_BOOT;
      role_q <= 1'b0;
      sw_rate_q <= `AP_RST_RATE;
      sw_fmt_q <= `AP_RST_FMT;
      sw_mod_q <= `AP_RST_TRANSMITTER_OPERATION_MODE;
      sw_cfg_q <= `AP_RST_CFG;
      sw_rxm_q <= `AP_RST_CFG;
      sw_lnk_q <= `AP_RST_CFG;
      ac_rate_q <= `AP_RST_RATE;
      ac_fmt_q <= `AP_RST_FMT;
      ac_mod_q <= `AP_RST_TRANSMITTER_OPERATION_MODE;
      ac_cfg_q <= `AP_RST_CFG;
      ac_rxm_q <= `AP_RST_CFG;
      reconf_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      st_q <= st_d;
      role_q <= role_d;
      sw_rate_q <= sw_rate_d;
      sw_fmt_q <= sw_fmt_d;
      sw_mod_q <= sw_mod_d;
      sw_cfg_q <= sw_cfg_d;
      sw_rxm_q <= sw_rxm_d;
      sw_lnk_q <= sw_lnk_d;
      ac_rate_q <= ac_rate_d;
      ac_fmt_q <= ac_fmt_d;
      ac_mod_q <= ac_mod_d;
      ac_cfg_q <= ac_cfg_d;
      ac_rxm_q <= ac_rxm_d;
      reconf_q <= reconf_d;
      rdata_q <= rdata_d;
    end
  end

  // Rate detection from the word select period; a stalled counter means no input.
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic ws_p_q;
  always_comb begin
    cnt_d = cnt_q;
    det_d = det_q;
    if (s2_q[1] && !ws_p_q) begin
      det_d = rate_code(cnt_q);
      cnt_d = '0;
    end else if (&cnt_q) begin
      det_d[1:0] = AP_FUND_NONE;
    end else begin
      cnt_d = cnt_q + 1'b1;
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_q <= '0;
      det_q <= {AP_SC_ONE, AP_FUND_NONE};
      ws_p_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      det_q <= det_d;
      ws_p_q <= s2_q[1];
    end
  end

  // Master clock synthesiser; master bit and word clocks are divided from it.
  logic [31:0] acc_q, acc_d;
  logic [7:0] div_q, div_d;
  logic [31:0] inc;
  always_comb begin
    unique case (ap_mclk_t'(ac_mod_q[`AP_F_MCLK]))
      AP_MCLK_441: inc = INC441;
      AP_MCLK_32: inc = INC32;
      AP_MCLK_48, AP_MCLK_OFF: inc = INC48;
    endcase
    acc_d = acc_q + inc;
    div_d = (acc_d[31] && !acc_q[31]) ? div_q + 8'h01 : div_q;
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      acc_q <= 32'h00000000;
      div_q <= 8'h00;
    end else begin
      acc_q <= acc_d;
      div_q <= div_d;
    end
  end

  // Pin directions and values; all inputs until configuration is loaded.
  logic [5:0] oe_q, oe_d;
  logic [5:0] po_q, po_d;
  logic [2:0] mem_q, mem_d;
  logic tx, spd, mst, mclk_en;
  always_comb begin
    tx = role_q;
    spd = tx ? ac_mod_q[`AP_B_SPDIF] : ac_rxm_q[`AP_B_SPDIF];
    mst = ac_cfg_q[`AP_B_MASTER];
    mclk_en = ac_mod_q[`AP_F_MCLK] != AP_MCLK_OFF && !(tx && spd);
    // Order: req, bclk, ws, data, spdif, mclk.
    oe_d = 6'h00;
    if (st_q == AP_ST_RUN) begin
      if (tx) begin
        oe_d = {1'b1, !spd && mst, !spd && mst, 1'b0, !spd && spdif_as_reset, 1'b1};
      end else begin
        oe_d = {1'b0, !spd, !spd, !spd, spd || spdif_as_reset, 1'b1};
      end
    end
    po_d[5] = ac_mod_q[`AP_B_REQPOL] ? req_active : !req_active;
    po_d[4] = div_q[1];
    po_d[3] = div_q[7];
    po_d[2] = arx_data_bit;
    po_d[1] = (!tx && spd) ? arx_spdif_bit : !ext_reset_req;
    po_d[0] = mclk_en && acc_q[31];
    mem_d = {mem_cs_src_n, mem_sck_src, mem_out_src};
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      oe_q <= 6'h00;
      po_q <= 6'h00;
      mem_q <= 3'h7;
    end else begin
      oe_q <= oe_d;
      po_q <= po_d;
      mem_q <= mem_d;
    end
  end

  // Mode outputs, direct data and wake-up.
  logic [3:0] rate_q, rate_d;
  logic wake_q, wake_d, dd_p_q;
  logic [2:0] dd_q, dd_d;
  ap_fmt_t fmt_q, fmt_d;
  always_comb begin
    rate_d = ac_rate_q[`AP_B_AUTO] ? det_q : ac_rate_q[`AP_F_RATE];
    unique case (ac_fmt_q)
      AP_FMT_C24: fmt_d = AP_FMT_C24;
      AP_FMT_C16: fmt_d = AP_FMT_C16;
      AP_FMT_DATA: fmt_d = AP_FMT_DATA;
      default: fmt_d = AP_FMT_PCM16;
    endcase
    wake_d = ac_mod_q[`AP_B_WAKE] && (s2_q[7] != dd_p_q);
    dd_d = ac_mod_q[`AP_B_DDEN] ? {s2_q[8] && s2_q[9], s2_q[7:6]} : 3'h0;
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      rate_q <= 4'h0;
      fmt_q <= AP_FMT_PCM16;
      wake_q <= 1'b0;
      dd_q <= 3'h0;
      dd_p_q <= 1'b0;
    end else begin
      rate_q <= rate_d;
      fmt_q <= fmt_d;
      wake_q <= wake_d;
      dd_q <= dd_d;
      dd_p_q <= s2_q[7];
    end
  end

  // Companding: the frame peak picks how many low bits the frame loses.
  logic [23:0] pk_q, pk_d, pk;
  logic [4:0] sh_q, sh_d;
  logic cv_q, cv_d;
  int len;
  int tgt;
  always_comb begin
    pk = (smp_valid && mag(smp_data) > pk_q) ? mag(smp_data) : pk_q;
    len = 0;
    for (int i = 0; i < 24; i++) begin
      if (pk[i]) len = i + 1;
    end
    tgt = (fmt_q == AP_FMT_C24) ? `AP_CMP_W24 : `AP_CMP_W16;
    pk_d = smp_frame_end ? 24'h000000 : pk;
    cv_d = smp_frame_end;
    sh_d = sh_q;
    if (smp_frame_end) begin
      sh_d = 5'h00;
      if ((fmt_q == AP_FMT_C24 || fmt_q == AP_FMT_C16) && len + 1 > tgt) begin
        sh_d = 5'(len + 1 - tgt);
      end
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      pk_q <= 24'h000000;
      sh_q <= 5'h00;
      cv_q <= 1'b0;
    end else begin
      pk_q <= pk_d;
      sh_q <= sh_d;
      cv_q <= cv_d;
    end
  end

  // S/PDIF: payload passes untouched; only the first status bits are gathered.
  logic [31:0] cs_q, cs_d, csw_q, csw_d;
  logic csv_q, csv_d, pv_q;
  logic [23:0] pp_q;
  always_comb begin
    cs_d = cs_q;
    csw_d = csw_q;
    csv_d = 1'b0;
    if (sp_valid && sp_idx <= `AP_CS_LAST) begin
      cs_d[sp_idx[4:0]] = sp_cs;
      if (sp_idx == `AP_CS_LAST) begin
        csw_d = cs_d;
        csv_d = 1'b1;
      end
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      cs_q <= 32'h00000000;
      csw_q <= 32'h00000000;
      csv_q <= 1'b0;
      pv_q <= 1'b0;
      pp_q <= 24'h000000;
    end else begin
      cs_q <= cs_d;
      csw_q <= csw_d;
      csv_q <= csv_d;
      pv_q <= sp_valid;
      pp_q <= sp_valid ? sp_payload : pp_q;
    end
  end

  assign reg_rdata = rdata_q;
  assign {mem_chip_select_n, mem_serial_clock, mem_serial_out} = mem_q;
  assign {req_oe, bclk_oe, ws_oe, data_oe, spdif_pin_oe, mclk_oe} = oe_q;
  assign {req_o, bclk_o, ws_o, data_o, spdif_pin_o, mclk_o} = po_q;
  assign {ser_data, ser_bclk, ser_ws} = s2_q[3:1];
  assign rx_req_seen = s2_q[4];
  assign spdif_in = s2_q[5];
  assign role_tx = role_q;
  assign {rate_scale, rate_fund} = rate_q;
  assign fmt_mode = fmt_q;
  assign rf_tx_enable = ac_mod_q[`AP_B_RFEN];
  assign audio_tx_power_down = ac_mod_q[`AP_B_PDN];
  assign wake_pulse = wake_q;
  assign dd_out = dd_q;
  assign cmp_shift = sh_q;
  assign cmp_valid = cv_q;
  assign sp_out_valid = pv_q;
  assign sp_out_payload = pp_q;
  assign cs_word = csw_q;
  assign cs_valid = csv_q;

  property p_mem_idle;
    @(posedge clock) disable iff (rst) $past(rst) |-> mem_chip_select_n && mem_serial_clock && mem_serial_out;
  endproperty
  a_mem_idle: assert property (p_mem_idle) else $error("memory pins not idle high after reset");
  property p_boot_in;
    @(posedge clock) disable iff (rst) $past(st_q == AP_ST_BOOT) |-> oe_q == 6'h00;
  endproperty
  a_boot_in: assert property (p_boot_in) else $error("pin driven before configuration");
  property p_hold;
    @(posedge clock) disable iff (rst) (st_q == AP_ST_BOOT && !cfg_done) |=> st_q == AP_ST_BOOT;
  endproperty
  a_hold: assert property (p_hold) else $error("left boot without configuration");
  property p_mclk_off;
    @(posedge clock) disable iff (rst) (ac_mod_q[1:0] == AP_MCLK_OFF) [*2] |-> !mclk_o;
  endproperty
  a_mclk_off: assert property (p_mclk_off) else $error("master clock toggles while off");
  property p_shadow;
    @(posedge clock) disable iff (rst) !reconf_q |=> $stable(ac_mod_q) && $stable(ac_fmt_q) && $stable(ac_rate_q);
  endproperty
  a_shadow: assert property (p_shadow) else $error("active setting changed without reconfigure");
  property p_req_pol;
    @(posedge clock) disable iff (rst) (!ac_mod_q[4] && req_active) |=> !req_o;
  endproperty
  a_req_pol: assert property (p_req_pol) else $error("active low request not low");
  property p_auto;
    @(posedge clock) disable iff (rst) ac_rate_q[0] |=> rate_q == $past(det_q);
  endproperty
  a_auto: assert property (p_auto) else $error("detected rate not reported");
  property p_nodet;
    @(posedge clock) disable iff (rst) (&cnt_q) ##1 (&cnt_q) |-> det_q[1:0] == AP_FUND_NONE;
  endproperty
  a_nodet: assert property (p_nodet) else $error("missing input not flagged");
  property p_cs;
    @(posedge clock) disable iff (rst) cs_valid |-> $past(sp_valid && sp_idx == 8'd31);
  endproperty
  a_cs: assert property (p_cs) else $error("status word at wrong bit");
  property p_pass;
    @(posedge clock) disable iff (rst) sp_valid |=> sp_out_valid && sp_out_payload == $past(sp_payload);
  endproperty
  a_pass: assert property (p_pass) else $error("payload altered");
  property p_iface;
    @(posedge clock) disable iff (rst) (st_q == AP_ST_RUN && role_q && ac_mod_q[2]) |=> !bclk_oe && !ws_oe;
  endproperty
  a_iface: assert property (p_iface) else $error("serial clocks driven in S/PDIF mode");
  property p_cmp;
    @(posedge clock) disable iff (rst) (smp_frame_end && fmt_q == AP_FMT_PCM16) |=> cmp_valid && cmp_shift == 5'h00;
  endproperty
  a_cmp: assert property (p_cmp) else $error("bits dropped without companding");
endmodule

// >>> ap_defs.svh
`ifndef AP_DEFS_SVH
`define AP_DEFS_SVH
// Register offsets.
`define AP_ADR_RATE 7'h01
`define AP_ADR_FMT 7'h51
`define AP_ADR_TRANSMITTER_OPERATION_MODE 7'h5a
`define AP_ADR_INCFG 7'h54
`define AP_ADR_RECEIVER_OPERATION_MODE 7'h4a
`define AP_ADR_LINK 7'h36
// Reset values.
`define AP_RST_RATE 8'h40
`define AP_RST_FMT 8'h00
`define AP_RST_TRANSMITTER_OPERATION_MODE 8'h00
`define AP_RST_CFG 8'h00
// Field positions.
`define AP_B_AUTO 0
`define AP_B_RECONF 4
`define AP_B_MASTER 7
`define AP_B_RFEN 7
`define AP_B_PDN 6
`define AP_B_WAKE 5
`define AP_B_REQPOL 4
`define AP_B_DDEN 3
`define AP_B_SPDIF 2
`define AP_F_RATE 6:3
`define AP_F_MCLK 1:0
// Timing, status and companding figures.
`define AP_CLK_HZ 200000000
`define AP_FS_48 48000
`define AP_FS_441 44100
`define AP_FS_32 32000
`define AP_MCLK_MUL 256
`define AP_TOL_SHIFT 6
`define AP_CS_LAST 8'd31
`define AP_CMP_W24 16
`define AP_CMP_W16 8
`endif

// >>> ap_pkg.sv
package ap_pkg;
  typedef enum logic [1:0] {AP_ST_BOOT = 2'b01, AP_ST_RUN = 2'b10} ap_state_t;
  typedef enum logic [7:0] {
    AP_FMT_PCM16 = 8'h00,
    AP_FMT_C24 = 8'h01,
    AP_FMT_C16 = 8'h04,
    AP_FMT_DATA = 8'h40
  } ap_fmt_t;
  typedef enum logic [1:0] {AP_FUND_48 = 2'b00, AP_FUND_441 = 2'b01, AP_FUND_32 = 2'b10,
    AP_FUND_NONE = 2'b11} ap_fund_t;
  typedef enum logic [1:0] {AP_SC_QUARTER = 2'b00, AP_SC_HALF = 2'b01, AP_SC_ONE = 2'b10} ap_scale_t;
  typedef enum logic [1:0] {AP_MCLK_OFF = 2'b00, AP_MCLK_48 = 2'b01, AP_MCLK_441 = 2'b10,
    AP_MCLK_32 = 2'b11} ap_mclk_t;
endpackage

// >>> ap_i2s_src.sv
module ap_i2s_src (
  input wire logic req_pin, // Request pin level.
  input wire logic pol, // Level meaning request active.
  input wire logic [9:0] half, // Bit clocks per word half.
  output logic bclk, // Bit clock, parked while paused.
  output logic ws, // Word select.
  output logic data // Serial data.
);
  timeunit 1ns;
  timeprecision 100ps;
  int n = 0;
  // External master; clock and data both park while not asked for data, so rate follows half.
  initial begin
    bclk = 1'b0;
    ws = 1'b0;
    data = 1'b0;
    forever begin
      #32;
      if (req_pin === pol) begin
        data = ~data;
        bclk = ~bclk;
        if (!bclk) begin
          n++;
          if (n >= half) begin
            n = 0;
            ws = ~ws;
          end
        end
      end
    end
  end
endmodule

// >>> test_audio_port_tx_config.sv
`include "ap_defs.svh"
`define CHK(v, e) begin checks++; if ((v) !== (e)) begin error_cnt++; $display("BAD t=%0t got=%h exp=%h", $time, (v), (e)); end end
module test_audio_port_tx_config;
  import ap_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  int error_cnt = 0;
  int checks = 0;
  int ex[4] = '{0, 61, 56, 40};
  int hv[4] = '{163, 177, 244, 488};
  logic [7:0] rv[4] = '{8'h40, 8'h48, 8'h50, 8'h18};
  logic [7:0] fc[4] = '{8'h00, 8'h04, 8'h40, 8'h01};
  logic [23:0] pk[4] = '{24'h030d40, 24'h00ea60, 24'h00ea60, 24'h00ea60};
  logic [4:0] sh[4] = '{5'h03, 5'h01, 5'h09, 5'h00};
  logic [7:0] cf[4] = '{8'h01, 8'h01, 8'h04, 8'h00};
  logic clock = 0, rst = 1, cfg_done = 0, transmitter_role = 1, reg_wr = 0, reg_rd = 0, pol = 0;
  logic mem_cs_src_n = 0, mem_sck_src = 0, mem_out_src = 0, req_active = 1, spdif_as_reset = 0;
  logic ext_reset_req = 0, smp_valid = 0, smp_frame_end = 0, sp_valid = 0, sp_cs = 0;
  logic [6:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, sp_idx = 0, reg_rdata;
  logic [23:0] smp_data = 0, sp_payload = 0, sp_out_payload;
  logic [9:0] half = 10'h0a3;
  logic mem_chip_select_n, mem_serial_clock, mem_serial_out, req_o, req_oe, bclk_o, bclk_oe, ws_o, ws_oe;
  logic data_o, data_oe, spdif_pin_o, spdif_pin_oe, mclk_o, mclk_oe, cmp_valid, sp_out_valid, cs_valid;
  logic rf_tx_enable, pb, pw, pd;
  logic role_tx, audio_tx_power_down, wake_pulse, two_wire = 0;
  logic [1:0] rate_scale, rate_fund;
  logic [2:0] dd_out, dd_pins = 3'h0;
  logic [4:0] cmp_shift;
  logic [31:0] cs_word;
  ap_fmt_t fmt_mode;
  // Board wires: whoever enables drives; an undriven request reads inactive.
  wire req_pin = req_oe ? req_o : ~pol;
  wire bclk_i = bclk_oe ? bclk_o : pb;
  wire ws_i = ws_oe ? ws_o : pw;

  ap_audio_port u_ap_audio_port (.clock, .rst, .cfg_done, .transmitter_role, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .mem_cs_src_n, .mem_sck_src, .mem_out_src, .mem_chip_select_n, .mem_serial_clock,
    .mem_serial_out, .req_i(req_pin), .req_o, .req_oe, .bclk_i, .bclk_o, .bclk_oe, .ws_i, .ws_o, .ws_oe,
    .data_i(pd), .data_o, .data_oe, .spdif_pin_i(1'b0), .spdif_pin_o, .spdif_pin_oe, .mclk_o, .mclk_oe,
    .direct_data_input(dd_pins), .two_wire_sel(two_wire), .req_active, .arx_data_bit(1'b0), .arx_spdif_bit(1'b0),
    .spdif_as_reset, .ext_reset_req, .smp_valid, .smp_data, .smp_frame_end, .cmp_shift, .cmp_valid,
    .sp_valid, .sp_payload, .sp_idx, .sp_cs, .sp_out_valid, .sp_out_payload, .cs_word, .cs_valid,
    .role_tx, .rate_scale, .rate_fund, .fmt_mode, .rf_tx_enable, .audio_tx_power_down,
    .wake_pulse, .dd_out, .ser_bclk(), .ser_ws(), .ser_data(), .rx_req_seen(), .spdif_in());

  ap_i2s_src u_ap_i2s_src (.req_pin(req_pin), .pol(pol), .half(half), .bclk(pb), .ws(pw), .data(pd));

  // Clock at 200 MHz.
  always #2.5 clock = ~clock;

  // Inputs always change 1 ns after the rising edge.
  task automatic nx;
    @(posedge clock);
    #1;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    nx;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    nx;
    reg_wr = 0;
  endtask

  // Read data is looked at only after it has surely landed and stands.
  task automatic rd(input logic [6:0] a, input logic [7:0] m, input logic [7:0] e);
    nx;
    reg_addr = a;
    reg_rd = 1;
    nx;
    reg_rd = 0;
    nx;
    `CHK(reg_rdata & m, e)
  endtask

  task automatic rcf(input logic [7:0] m);
    wr(`AP_ADR_TRANSMITTER_OPERATION_MODE, m);
    wr(`AP_ADR_LINK, 8'h10);
    repeat (5) nx;
  endtask

  task automatic results;
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Watchdog so a hang still ends in the report.
  initial begin
    repeat (90000) @(posedge clock);
    error_cnt++;
    results;
  end

  // Main sequence.
  initial begin
    int n;
    int k;
    logic mp;
    repeat (12) nx;
    `CHK(req_oe | bclk_oe | ws_oe | data_oe | spdif_pin_oe | mclk_oe, 1'b0)
    `CHK({mem_chip_select_n, mem_serial_clock, mem_serial_out}, 3'h7)
    rst = 0;
    repeat (2) nx;
    `CHK(mem_serial_out, 1'b0)
    rd(`AP_ADR_RATE, 8'hff, 8'h40);
    rd(`AP_ADR_FMT, 8'hff, 8'h00);
    rd(`AP_ADR_TRANSMITTER_OPERATION_MODE, 8'hff, 8'h00);
    rd(7'h10, 8'hff, 8'h00);
    $display("reset test done");
    wr(`AP_ADR_INCFG, 8'h80);
    rcf(8'h00);
    `CHK(req_oe | bclk_oe | mclk_oe, 1'b0)
    cfg_done = 1;
    nx;
    cfg_done = 0;
    repeat (3) nx;
    `CHK({req_oe, bclk_oe, ws_oe, data_oe, mclk_oe}, 5'h1d)
    `CHK(role_tx, 1'b1)
    wr(`AP_ADR_INCFG, 8'h00);
    rcf(8'h00);
    `CHK({req_oe, bclk_oe, ws_oe, data_oe, spdif_pin_oe, mclk_oe}, 6'h21)
    `CHK({req_o, mclk_o}, 2'h0)
    wr(`AP_ADR_TRANSMITTER_OPERATION_MODE, 8'h10);
    spdif_as_reset = 1;
    ext_reset_req = 1;
    repeat (5) nx;
    `CHK(req_o, 1'b0)
    `CHK({spdif_pin_oe, spdif_pin_o}, 2'h2)
    $display("direction test done");
    pol = 1;
    for (int c = 1; c < 4; c++) begin
      rcf(8'h90 | c[7:0]);
      `CHK({req_o, rf_tx_enable}, 2'h3)
      n = 0;
      mp = mclk_o;
      repeat (1000) begin
        nx;
        if (mclk_o && !mp) n++;
        mp = mclk_o;
      end
      `CHK(n == ex[c] || n == ex[c] + 1, 1'b1)
    end
    $display("clock test done");
    wr(`AP_ADR_RATE, 8'h01);
    rcf(8'h90);
    for (int i = 0; i < 4; i++) begin
      half = hv[i][9:0];
      repeat (64 * hv[i]) nx;
      rd(`AP_ADR_RATE, i < 3 ? 8'h78 : 8'h18, rv[i]);
      `CHK({rate_scale, rate_fund} & (i < 3 ? 4'hf : 4'h3), rv[i][6:3])
    end
    $display("rate test done");
    foreach (fc[j]) begin
      wr(`AP_ADR_FMT, fc[j]);
      rcf(8'h90);
      `CHK(fmt_mode, fc[j])
    end
    // Each frame runs under its own format, so the second frame never starts in the edge that ended the first.
    for (int i = 0; i < 4; i++) begin
      wr(`AP_ADR_FMT, cf[i]);
      rcf(8'h90);
      smp_valid = 1;
      smp_data = 24'hfffffb;
      nx;
      smp_data = pk[i];
      smp_frame_end = 1;
      nx;
      smp_valid = 0;
      smp_frame_end = 0;
      k = 0;
      while (cmp_valid !== 1'b1 && k < 4) begin
        nx;
        k++;
      end
      `CHK({k < 4, cmp_shift}, {1'b1, sh[i]})
    end
    $display("compand test done");
    rcf(8'hf8);
    dd_pins = 3'h7;
    repeat (3) nx;
    `CHK({wake_pulse, audio_tx_power_down, dd_out}, 5'h1b)
    two_wire = 1;
    repeat (3) nx;
    `CHK({wake_pulse, dd_out}, 4'h7)
    $display("direct data test done");
    for (int i = 0; i < 32; i++) begin
      sp_valid = 1;
      sp_idx = i[7:0];
      sp_cs = i[0] ^ i[3];
      sp_payload = {i[7:0], 16'h5a3c};
      nx;
    end
    sp_valid = 0;
    `CHK({sp_out_valid, sp_out_payload}, {1'b1, 24'h1f5a3c})
    `CHK({cs_valid, cs_word}, {1'b1, 32'h55aa55aa})
    rcf(8'h94);
    `CHK({req_oe, bclk_oe, spdif_pin_oe}, 3'h4)
    $display("spdif test done");
    // Second reset in mid-run, coming back in receiver role.
    rst = 1;
    transmitter_role = 0;
    repeat (4) nx;
    `CHK({mem_chip_select_n, mem_serial_clock, mem_serial_out, req_oe, spdif_pin_oe}, 5'h1c)
    rst = 0;
    cfg_done = 1;
    nx;
    cfg_done = 0;
    repeat (3) nx;
    `CHK({role_tx, req_oe, bclk_oe, ws_oe, data_oe, spdif_pin_oe, mclk_oe}, 7'h1f)
    wr(`AP_ADR_RECEIVER_OPERATION_MODE, 8'h04);
    rcf(8'h00);
    `CHK({req_oe, bclk_oe, ws_oe, data_oe, spdif_pin_oe, mclk_oe}, 6'h03)
    $display("receiver test done");
    results;
  end
endmodule
